// [hw/vectored_interrupt_control.v]
// Vectored interrupt controller with Avalon-MM register slave
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// - Interval timer event requests slot 1, vector entry 0002H, highest priority
// - Both-edge pin detects rise and fall, sharing slot 1 with interval timer
// - Pin zero selectable edge slot 2 (0004H); pin one slot 3 (0006H)
// - Serial completion requests slot 4, vector entry 0008H
// - Timer modulo match requests slot 5, vector entry 000AH
// - Pulse generator match requests slot 6, vector entry 000CH
// - Pin rise or selected key fall sets a testable flag, no vector
// - Clock timer only sets its testable flag, no vector
// - Simultaneous vectored requests resolved lowest slot number first
// - Vectoring needs both the source enable and the master enable
// - Each vector entry holds a software address, output on acceptance
// - Nesting allowed for the slot chosen by the priority select register
// - All request flags readable by software
// - Enabled requests release standby; disabled ones do not
// - Flags set on event, cleared automatically when the vector is accepted
// - Slot request is flag and enable together, also the standby release
// - Reset clears all request and enable flags
// - Priority select register uses only three low bits
module vectored_interrupt_control #(
	parameter VEC_W = 16
) (
	input wire ref_clk,
	input wire rstn,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire interval_timer_irq,
	input wire both_edge_pin_irq,
	input wire ext_pin_irq_zero,
	input wire ext_pin_irq_one,
	input wire serial_done_irq,
	input wire timer_match_irq,
	input wire pulse_gen_match_irq,
	input wire key_or_pin_testable_irq,
	input wire [7:0] key_input_line,
	input wire clock_timer_testable_irq,
	input wire cpu_ack,
	input wire cpu_return,
	output reg vec_req,
	output reg [2:0] vec_slot,
	output reg [VEC_W-1:0] vec_addr,
	output reg standby_release,
	output reg irq
);
`include "vic_map.vh"

localparam ST_IDLE = 3'b001;
localparam ST_LOW = 3'b010;
localparam ST_HIGH = 3'b100;

reg [`NUM_FLAGS-1:0] source_request_flag;
reg [`NUM_FLAGS-1:0] source_enable_flag;
reg master_irq_enable;
reg [2:0] priority_select_reg;
reg [15:0] edge_mode;
reg [VEC_W-1:0] vector_entry [0:`NUM_SLOTS-1];
reg [2:0] state;
reg nested;
reg key_level_prev;

wire [`NUM_FLAGS-1:0] pending;
wire [`NUM_SLOTS-1:0] vector_slot_request;
wire edge_both;
wire edge_zero;
wire edge_one;
wire edge_pin_two;
wire key_level;
wire key_fall;
wire [2:0] cand;
wire [2:0] hi_slot;
wire [7:0] slot_req_wide;
wire hi_req;
wire [2:0] offer;
wire slot_is_high;
wire take;
wire wr_fire;
wire [7:0] vec_off;
wire [2:0] vec_idx;
reg [`NUM_FLAGS-1:0] events;
reg [`NUM_FLAGS-1:0] sw_set;
reg [`NUM_FLAGS-1:0] sw_clr;
reg [`NUM_FLAGS-1:0] ack_clr;
reg [`NUM_FLAGS-1:0] next_flags;
reg [2:0] next_state;
reg next_nested;
reg [31:0] next_readdata;

// Lowest numbered requesting slot wins
function [2:0] pick_slot;
	input [`NUM_SLOTS-1:0] req;
	integer i;
	begin
		pick_slot = `SLOT_NONE;
		for (i = `NUM_SLOTS - 1; i >= 0; i = i - 1) begin
			if (req[i]) begin
				pick_slot = i[2:0];
			end
		end
	end
endfunction

// Whether a bus address falls in the vector entry group, word aligned
function is_vector_addr;
	input [7:0] addr;
	begin
		is_vector_addr = (addr >= `VIC_VEC_BASE) && (addr <= `VIC_VEC_LAST)
			&& (addr[1:0] == 2'h0);
	end
endfunction

edge_pick u_both (
	.ref_clk(ref_clk),
	.rstn(rstn),
	.level(both_edge_pin_irq),
	.mode(`EDGE_BOTH),
	.pulse(edge_both)
);

edge_pick u_zero (
	.ref_clk(ref_clk),
	.rstn(rstn),
	.level(ext_pin_irq_zero),
	.mode(edge_mode[`EDGE_ZERO_LO+1:`EDGE_ZERO_LO]),
	.pulse(edge_zero)
);

edge_pick u_one (
	.ref_clk(ref_clk),
	.rstn(rstn),
	.level(ext_pin_irq_one),
	.mode(edge_mode[`EDGE_ONE_LO+1:`EDGE_ONE_LO]),
	.pulse(edge_one)
);

edge_pick u_two (
	.ref_clk(ref_clk),
	.rstn(rstn),
	.level(key_or_pin_testable_irq),
	.mode(`EDGE_RISE),
	.pulse(edge_pin_two)
);

// Selected keys act as one wired line: any low key masks the others
assign key_level = &(key_input_line | ~edge_mode[`EDGE_KEY_SEL_LO+7:`EDGE_KEY_SEL_LO]);
assign key_fall = key_level_prev & ~key_level & (|edge_mode[`EDGE_KEY_SEL_LO+7:`EDGE_KEY_SEL_LO]);

always @* begin
	events = {`NUM_FLAGS{1'b0}};
	events[`FLAG_INTERVAL] = interval_timer_irq;
	events[`FLAG_BOTH_EDGE] = edge_both;
	events[`FLAG_PIN_ZERO] = edge_zero;
	events[`FLAG_PIN_ONE] = edge_one;
	events[`FLAG_SERIAL] = serial_done_irq;
	events[`FLAG_TIMER] = timer_match_irq;
	events[`FLAG_PULSE_GEN] = pulse_gen_match_irq;
	events[`FLAG_KEY] = edge_mode[`EDGE_KEY_MODE] ? key_fall : edge_pin_two;
	events[`FLAG_CLOCK_TIMER] = clock_timer_testable_irq;
end

assign pending = source_request_flag & source_enable_flag;

// Slot 1 is shared by two sources; testable flags 7 and 8 map to no slot
assign vector_slot_request[0] = pending[`FLAG_INTERVAL] | pending[`FLAG_BOTH_EDGE];
genvar g;
generate
	for (g = 1; g < `NUM_SLOTS; g = g + 1) begin : g_slot
		assign vector_slot_request[g] = pending[g + 1];
	end
endgenerate

assign cand = pick_slot(vector_slot_request);
// Priority code 0 or 7 points past the slots, so nothing nests then
assign hi_slot = priority_select_reg - 3'h1;
assign slot_req_wide = {{(8-`NUM_SLOTS){1'b0}}, vector_slot_request};
assign hi_req = slot_req_wide[hi_slot];

// Inside a low handler only the selected slot may cut in, whatever else waits
assign offer = state[1] ? (hi_req ? hi_slot : `SLOT_NONE) : cand;
assign slot_is_high = ({1'b0, vec_slot} + 4'h1) == {1'b0, priority_select_reg};
assign take = vec_req & cpu_ack;
assign wr_fire = avs_write & ~avs_waitrequest;
assign vec_off = avs_address - `VIC_VEC_BASE;
assign vec_idx = vec_off[4:2];

// Clear only the flags that caused the accepted vector
always @* begin
	ack_clr = {`NUM_FLAGS{1'b0}};
	if (take) begin
		if (vec_slot == 3'h0) begin
			ack_clr[`FLAG_INTERVAL] = pending[`FLAG_INTERVAL];
			ack_clr[`FLAG_BOTH_EDGE] = pending[`FLAG_BOTH_EDGE];
		end else begin
			ack_clr[vec_slot + 3'h1] = 1'b1;
		end
	end
end

always @* begin
	sw_set = {`NUM_FLAGS{1'b0}};
	sw_clr = {`NUM_FLAGS{1'b0}};
	if (wr_fire && avs_address == `VIC_SET) begin
		sw_set = avs_writedata[`NUM_FLAGS-1:0];
	end
	if (wr_fire && avs_address == `VIC_CLEAR) begin
		sw_clr = avs_writedata[`NUM_FLAGS-1:0];
	end
end

// A new event wins over any clear in the same cycle
always @* begin
	next_flags = (source_request_flag & ~sw_clr & ~ack_clr) | sw_set | events;
end

always @* begin
	next_state = state;
	next_nested = nested;
	if (take) begin
		if (state[0]) begin
			next_state = slot_is_high ? ST_HIGH : ST_LOW;
			next_nested = 1'b0;
		end else begin
			next_state = ST_HIGH;
			next_nested = 1'b1;
		end
	end else if (cpu_return) begin
		case (state)
			ST_HIGH: begin
				next_state = nested ? ST_LOW : ST_IDLE;
				next_nested = 1'b0;
			end
			ST_LOW: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end
end

always @* begin
	next_readdata = 32'h00000000;
	if (avs_address == `VIC_ENABLE) begin
		next_readdata[`NUM_FLAGS-1:0] = source_enable_flag;
	end else if (avs_address == `VIC_STATUS) begin
		next_readdata[`NUM_FLAGS-1:0] = source_request_flag;
	end else if (avs_address == `VIC_MASTER) begin
		next_readdata[0] = master_irq_enable;
	end else if (avs_address == `VIC_PRIO) begin
		next_readdata[2:0] = priority_select_reg;
	end else if (avs_address == `VIC_EDGE) begin
		next_readdata[15:0] = edge_mode;
	end else if (avs_address == `VIC_STATE) begin
		next_readdata[2:0] = state;
		next_readdata[3] = nested;
		next_readdata[6:4] = vec_slot;
		next_readdata[7] = vec_req;
	end else if (is_vector_addr(avs_address)) begin
		next_readdata[VEC_W-1:0] = vector_entry[vec_idx];
	end
end

// One wait cycle per access; write lands on the edge where wait is low
always @(posedge ref_clk or negedge rstn) begin
	if (!rstn) begin
		avs_waitrequest <= 1'b1;
		avs_readdata <= 32'h00000000;
	end else begin
		if ((avs_read | avs_write) & avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= next_readdata;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end
end

always @(posedge ref_clk or negedge rstn) begin
	if (!rstn) begin
		source_request_flag <= `RST_FLAGS;
		source_enable_flag <= `RST_FLAGS;
		master_irq_enable <= 1'b0;
		priority_select_reg <= `RST_PRIO;
		edge_mode <= `RST_EDGE;
	end else begin
		source_request_flag <= next_flags;
		if (wr_fire) begin
			if (avs_address == `VIC_ENABLE) begin
				source_enable_flag <= avs_writedata[`NUM_FLAGS-1:0];
			end else if (avs_address == `VIC_MASTER) begin
				master_irq_enable <= avs_writedata[0];
			end else if (avs_address == `VIC_PRIO) begin
				priority_select_reg <= avs_writedata[2:0];
			end else if (avs_address == `VIC_EDGE) begin
				edge_mode <= avs_writedata[15:0];
			end
		end
	end
end

genvar v;
generate
	for (v = 0; v < `NUM_SLOTS; v = v + 1) begin : g_vec
		always @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				vector_entry[v] <= `RST_VECTOR;
			end else if (wr_fire && is_vector_addr(avs_address) && vec_idx == v) begin
				vector_entry[v] <= avs_writedata[VEC_W-1:0];
			end
		end
	end
endgenerate

always @(posedge ref_clk or negedge rstn) begin
	if (!rstn) begin
		key_level_prev <= 1'b1;
		state <= ST_IDLE;
		nested <= 1'b0;
		vec_req <= 1'b0;
		vec_slot <= `SLOT_NONE;
		vec_addr <= {VEC_W{1'b0}};
		standby_release <= 1'b0;
		irq <= 1'b0;
	end else begin
		key_level_prev <= key_level;
		state <= next_state;
		nested <= next_nested;
		// Re-arbitrate every cycle so late, higher requests overtake
		if (take || state[2]) begin
			vec_req <= 1'b0;
		end else begin
			vec_req <= master_irq_enable & (offer != `SLOT_NONE);
		end
		if (!take) begin
			vec_slot <= offer;
			if (offer != `SLOT_NONE) begin
				vec_addr <= vector_entry[offer];
			end
		end
		// Standby release ignores the master enable on purpose, testable flags included
		standby_release <= |pending;
		irq <= |pending;
	end
end

endmodule

// [hw/vic_map.vh]
// Register offsets, field positions and reset values of the interrupt controller
`ifndef VIC_MAP_VH
`define VIC_MAP_VH

// Byte offsets on the register bus
`define VIC_ENABLE 8'h00
`define VIC_STATUS 8'h04
`define VIC_CLEAR 8'h08
`define VIC_SET 8'h0C
`define VIC_MASTER 8'h10
`define VIC_PRIO 8'h14
`define VIC_EDGE 8'h18
`define VIC_STATE 8'h1C
`define VIC_VEC_BASE 8'h20
`define VIC_VEC_LAST 8'h34

// Request and enable flag positions
`define FLAG_INTERVAL 0
`define FLAG_BOTH_EDGE 1
`define FLAG_PIN_ZERO 2
`define FLAG_PIN_ONE 3
`define FLAG_SERIAL 4
`define FLAG_TIMER 5
`define FLAG_PULSE_GEN 6
`define FLAG_KEY 7
`define FLAG_CLOCK_TIMER 8
`define NUM_FLAGS 9
`define NUM_SLOTS 6

// Edge register fields
`define EDGE_ZERO_LO 0
`define EDGE_ONE_LO 2
`define EDGE_KEY_MODE 4
`define EDGE_KEY_SEL_LO 8

// Edge mode codes
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_BOTH 2'h2
`define EDGE_OFF 2'h3

// Reset values
`define RST_FLAGS 9'h000
`define RST_PRIO 3'h0
`define RST_EDGE 16'h0000
`define RST_VECTOR 16'h0000

// Slot code shown when no slot is requested
`define SLOT_NONE 3'h7

`endif

// [hw/edge_pick.v]
// Edge detector with selectable rising, falling, both or no edge
`timescale 1ns/1ps
module edge_pick (
	input wire ref_clk,
	input wire rstn,
	input wire level,
	input wire [1:0] mode,
	output reg pulse
);
`include "vic_map.vh"

reg prev;

always @(posedge ref_clk or negedge rstn) begin
	if (!rstn) begin
		prev <= 1'b0;
	end else begin
		prev <= level;
	end
end

always @* begin
	case (mode)
		`EDGE_RISE: pulse = level & ~prev;
		`EDGE_FALL: pulse = ~level & prev;
		`EDGE_BOTH: pulse = level ^ prev;
		default: pulse = 1'b0;
	endcase
end

endmodule

// [tb/cpu_model.sv]
// CPU-side partner that takes vectors and returns from handlers
`timescale 1ns/1ps
module cpu_model #(
	parameter int RET = 30
) (
	input wire ref_clk,
	input wire rstn,
	input wire vec_req,
	output logic cpu_ack,
	output logic cpu_return
);
	initial begin
		cpu_ack = 1'b0;
		cpu_return = 1'b0;
	end
	// Prompt or slow ack at random, once a vector is seen offered; vec_req is not checked again before the ack
	always begin
		@(posedge ref_clk);
		if (rstn && vec_req) begin
			repeat ($urandom % 3) @(posedge ref_clk);
			cpu_ack <= 1'b1;
			@(posedge ref_clk);
			cpu_ack <= 1'b0;
			fork
				begin
					repeat (RET) @(posedge ref_clk);
					cpu_return <= 1'b1;
					@(posedge ref_clk);
					cpu_return <= 1'b0;
				end
			join_none
		end
	end
endmodule

// [tb/vectored_interrupt_control_props.sv]
// Checker for bus handshake and vector outputs
`timescale 1ns/1ps
module vic_props (
	input wire ref_clk,
	input wire rstn,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire cpu_ack,
	input wire vec_req,
	input wire [2:0] vec_slot,
	input wire standby_release,
	input wire irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_answer_next:
		assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("late bus answer");
	a_wait_short:
		assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_wait_cause:
		assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("answer without request");
	a_rdata_hold:
		assert property (!(avs_read || avs_write) && avs_waitrequest |=> $stable(avs_readdata))
		else $error("read data moved while idle");
	a_ack_drops:
		assert property (vec_req && cpu_ack |=> !vec_req)
		else $error("request kept after accept");
	a_slot_range:
		assert property (vec_req |-> vec_slot <= 3'h5)
		else $error("bad slot");
	a_req_pending:
		assert property (vec_req |-> standby_release)
		else $error("vector without enabled flag");
	a_irq_standby:
		assert property (irq == standby_release)
		else $error("irq and standby release differ");
endmodule
bind vectored_interrupt_control vic_props u_props (.ref_clk, .rstn, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .cpu_ack, .vec_req, .vec_slot, .standby_release, .irq);

// [tb/tb_vectored_interrupt_control.sv]
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`include "vic_map.vh"
module tb_vectored_interrupt_control;
	localparam logic [8:0] PIN = 9'h08E;
	logic ref_clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [7:0] avs_address = 8'h00, keys = 8'hFF;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, r;
	logic [8:0] src = 9'h000;
	logic avs_waitrequest, cpu_ack, cpu_return, vec_req, standby_release, irq;
	logic [2:0] vec_slot;
	logic [15:0] vec_addr;
	logic [15:0] vec [8];
	logic [2:0] got [$];
	int exp_q [$];
	int num_errors = 0, total_checks = 0, i;
	initial forever #20 ref_clk = ~ref_clk;
	vectored_interrupt_control uut (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .interval_timer_irq(src[0]),
		.both_edge_pin_irq(src[1]), .ext_pin_irq_zero(src[2]), .ext_pin_irq_one(src[3]),
		.serial_done_irq(src[4]), .timer_match_irq(src[5]), .pulse_gen_match_irq(src[6]),
		.key_or_pin_testable_irq(src[7]), .key_input_line(keys),
		.clock_timer_testable_irq(src[8]), .cpu_ack, .cpu_return, .vec_req, .vec_slot,
		.vec_addr, .standby_release, .irq);
	cpu_model #(.RET(30)) cpu (.ref_clk, .rstn, .vec_req, .cpu_ack, .cpu_return);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			$display("BAD %0t %h %h", $time, g, e);
			num_errors++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// Waits for the answer however long; only the watchdog ends a hang
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		{avs_address, avs_write, avs_read, avs_writedata} <= {a, w, !w, d};
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		{avs_write, avs_read} <= 2'h0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(r, e);
	endtask
	task automatic stop_test;
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Order of accepted slots, judged against the bench queue
	task automatic drain;
		int n;
		n = 0;
		while (got.size() < exp_q.size() && n < 500) begin
			tick(1);
			n++;
		end
		tick(40);
		chk(got.size(), exp_q.size());
		foreach (exp_q[k]) if (k < got.size()) chk(got[k], exp_q[k]);
	endtask
	always @(posedge ref_clk)
		if (rstn && vec_req === 1'b1 && cpu_ack === 1'b1) begin
			got.push_back(vec_slot);
			chk(vec_addr, vec[vec_slot]);
		end
	initial begin
		tick(20000);
		num_errors++;
		stop_test;
	end
	initial begin
		r = $urandom(32'h2201E626);
		tick(12);
		rstn <= 1'b1;
		tick(1);
		rd(`VIC_ENABLE, 32'h0);
		rd(`VIC_STATUS, 32'h0);
		wr(8'h40, 32'hFFFFFFFF);
		rd(8'h40, 32'h0);
		wr(`VIC_PRIO, 32'h0000000C);
		rd(`VIC_PRIO, 32'h4);
		for (i = 0; i < 6; i++) begin
			vec[i] = 16'($urandom);
			wr(8'(`VIC_VEC_BASE + 4 * i), vec[i]);
		end
		for (i = 0; i < 6; i++) rd(8'(`VIC_VEC_BASE + 4 * i), vec[i]);
		// Pins stay high over the read; a pulse source drops after one edge
		for (i = 0; i < 9; i++) begin
			wr(`VIC_ENABLE, 32'h1 << i);
			src[i] <= 1'b1;
			tick(1);
			if (!PIN[i]) src[i] <= 1'b0;
			tick(3);
			rd(`VIC_STATUS, 32'h1 << i);
			chk(irq, 1'b1);
			src[i] <= 1'b0;
			tick(3);
			wr(`VIC_CLEAR, 32'h1FF);
			tick(2);
			chk(irq, 1'b0);
		end
		wr(`VIC_EDGE, 32'h00000F10);
		wr(`VIC_CLEAR, 32'h1FF);
		keys <= 8'hFB;
		tick(4);
		rd(`VIC_STATUS, 32'h080);
		chk(standby_release, 1'b0);
		wr(`VIC_CLEAR, 32'h1FF);
		keys <= 8'hFA;
		tick(4);
		rd(`VIC_STATUS, 32'h0);
		wr(`VIC_ENABLE, 32'h180);
		wr(`VIC_MASTER, 32'h1);
		wr(`VIC_SET, 32'h1A0);
		tick(10);
		chk(vec_req, 1'b0);
		chk(irq, 1'b1);
		chk(standby_release, 1'b1);
		wr(`VIC_MASTER, 32'h0);
		wr(`VIC_ENABLE, 32'h1FF);
		tick(10);
		chk(vec_req, 1'b0);
		wr(`VIC_CLEAR, 32'h1FF);
		wr(`VIC_MASTER, 32'h1);
		wr(`VIC_SET, 32'h024);
		exp_q = {1, 4};
		drain;
		wr(`VIC_SET, 32'h020);
		tick(8);
		wr(`VIC_SET, 32'h018);
		exp_q = {1, 4, 4, 3, 2};
		drain;
		rd(`VIC_STATUS, 32'h0);
		stop_test;
	end
endmodule
